// ### tx_path_pkg.sv
// constants and types shared by the transmit buffer command path
package tx_path_pkg;

	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int FIFO_AW = 4;
	localparam int FIFO_DEPTH = 16;
	localparam int STS_AW = 3;
	localparam int STS_DEPTH = 8;

	// register byte addresses
	localparam logic [7:0] REG_DATA = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_SPACE = 8'h08;
	localparam logic [7:0] REG_FLAGS = 8'h0C;
	localparam logic [7:0] REG_THRESH = 8'h10;

	// flag register bits
	localparam int FLAG_TXERR = 0;
	localparam int FLAG_DONE = 1;
	localparam int FLAG_THRESH = 2;

	// first command word fields
	localparam int A_IOC = 31;
	localparam int A_ALIGN_HI = 25;
	localparam int A_ALIGN_LO = 24;
	localparam int A_OFF_HI = 20;
	localparam int A_OFF_LO = 16;
	localparam int A_FIRST = 13;
	localparam int A_LAST = 12;
	localparam int A_SIZE_HI = 10;
	// second command word fields
	localparam int B_TAG_HI = 31;
	localparam int B_TAG_LO = 16;
	localparam int B_LEN_HI = 10;

	localparam logic [1:0] ALIGN_16 = 2'h1;
	localparam logic [1:0] ALIGN_32 = 2'h2;
	localparam logic [10:0] ROUND_16 = 11'h003;
	localparam logic [10:0] ROUND_32 = 11'h007;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_CMD_A = 2'b00,
		ST_CMD_B = 2'b01,
		ST_PAYLOAD = 2'b10,
		ST_PAD = 2'b11
	} parse_state_t;

	typedef struct packed {
		logic [31:0] data;
		logic [3:0] keep;
		logic buf_end;
		logic ioc;
		logic pkt_end;
		logic err;
		logic [15:0] tag;
		logic [10:0] len;
	} tx_beat_t;

endpackage

// ### tx_buffer_command_path.sv
// transmit buffer command parser with register bus and status queue
`timescale 1ns/1ps
`default_nettype none

module tx_buffer_command_path (
	input wire logic i_clk_sys, // system clock
	input wire logic i_rst, // async reset, active high
	input wire logic [7:0] i_s_axi_awaddr, // write address
	input wire logic i_s_axi_awvalid, // write address valid
	output logic o_s_axi_awready, // write address ready
	input wire logic [31:0] i_s_axi_wdata, // write data
	input wire logic [3:0] i_s_axi_wstrb, // write strobes
	input wire logic i_s_axi_wvalid, // write data valid
	output logic o_s_axi_wready, // write data ready
	output logic [1:0] o_s_axi_bresp, // write response
	output logic o_s_axi_bvalid, // write response valid
	input wire logic i_s_axi_bready, // write response ready
	input wire logic [7:0] i_s_axi_araddr, // read address
	input wire logic i_s_axi_arvalid, // read address valid
	output logic o_s_axi_arready, // read address ready
	output logic [31:0] o_s_axi_rdata, // read data
	output logic [1:0] o_s_axi_rresp, // read response
	output logic o_s_axi_rvalid, // read data valid
	input wire logic i_s_axi_rready, // read data ready
	output logic [31:0] o_tx_data, // payload word to transmitter
	output logic [3:0] o_tx_keep, // valid bytes of the word
	output logic o_tx_last, // last word of packet
	output logic o_tx_valid, // payload word valid
	input wire logic i_tx_ready, // transmitter accepts word
	output logic o_tx_error_flag, // sticky transmit error
	output logic o_buffer_done_flag, // sticky buffer completion
	output logic o_status_level_reached // status count at threshold
);

	localparam int FIFO_DEPTH = tx_path_pkg::FIFO_DEPTH;
	localparam int FIFO_AW = tx_path_pkg::FIFO_AW;
	localparam int STS_DEPTH = tx_path_pkg::STS_DEPTH;
	localparam int STS_AW = tx_path_pkg::STS_AW;

	// register bus
	logic aw_held, w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic aw_hs, w_hs, do_write, ar_hs;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;

	// data fifo, status fifo, output buffer
	logic [31:0] fifo_mem [FIFO_DEPTH];
	logic [FIFO_AW:0] fifo_wp, fifo_rp, fifo_cnt;
	logic [31:0] sts_mem [STS_DEPTH];
	logic [STS_AW:0] sts_wp, sts_rp, sts_cnt;
	tx_path_pkg::tx_beat_t obuf [2];
	logic obuf_wp, obuf_rp;
	logic [1:0] obuf_cnt;

	logic [15:0] half_low;
	logic half_pending;
	logic data_push, overflow, fifo_pop, fifo_empty;
	logic sts_push, sts_pop, sts_full;
	logic [7:0] thresh;
	logic [2:0] flags;

	// parser
	tx_path_pkg::parse_state_t state;
	logic [31:0] cmd_a, cmd_b_ref;
	logic [10:0] wcnt, wtot, wpad;
	logic [11:0] tot_bytes, pkt_bytes, next_pkt_bytes;
	logic [4:0] offset;
	logic pkt_err, cmdb_mismatch, len_mismatch;
	logic [3:0] keep;
	logic [2:0] keep_cnt;
	logic beat_push, obuf_ready, out_hs;
	tx_path_pkg::tx_beat_t beat;

	assign aw_hs = i_s_axi_awvalid & o_s_axi_awready;
	assign w_hs = i_s_axi_wvalid & o_s_axi_wready;
	assign o_s_axi_awready = ~aw_held & ~o_s_axi_bvalid;
	assign o_s_axi_wready = ~w_held & ~o_s_axi_bvalid;
	assign do_write = (aw_held | aw_hs) & (w_held | w_hs) & ~o_s_axi_bvalid;
	assign wr_addr = aw_held ? aw_addr : i_s_axi_awaddr;
	assign wr_data = w_held ? w_data : i_s_axi_wdata;
	assign wr_strb = w_held ? w_strb : i_s_axi_wstrb;
	assign o_s_axi_arready = ~o_s_axi_rvalid;
	assign ar_hs = i_s_axi_arvalid & o_s_axi_arready;

	// address and data may arrive in either order
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (do_write) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
		end else begin
			if (aw_hs) begin
				aw_held <= 1'b1;
				aw_addr <= i_s_axi_awaddr;
			end
			if (w_hs) begin
				w_held <= 1'b1;
				w_data <= i_s_axi_wdata;
				w_strb <= i_s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_s_axi_bvalid <= 1'b0;
			o_s_axi_bresp <= tx_path_pkg::RESP_OKAY;
		end else if (do_write) begin
			o_s_axi_bvalid <= 1'b1;
			case (wr_addr)
				tx_path_pkg::REG_DATA, tx_path_pkg::REG_FLAGS,
				tx_path_pkg::REG_THRESH: o_s_axi_bresp <= tx_path_pkg::RESP_OKAY;
				default: o_s_axi_bresp <= tx_path_pkg::RESP_SLVERR;
			endcase
		end else if (i_s_axi_bready) begin
			o_s_axi_bvalid <= 1'b0;
		end
	end

	// reads; a status read pops the status fifo
	assign sts_pop = ar_hs & (i_s_axi_araddr == tx_path_pkg::REG_STATUS) &
		(sts_cnt != '0);
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_rdata <= 32'h0000_0000;
			o_s_axi_rresp <= tx_path_pkg::RESP_OKAY;
		end else if (ar_hs) begin
			o_s_axi_rvalid <= 1'b1;
			o_s_axi_rresp <= tx_path_pkg::RESP_OKAY;
			case (i_s_axi_araddr)
				tx_path_pkg::REG_STATUS: o_s_axi_rdata <= (sts_cnt != '0) ?
					sts_mem[sts_rp[STS_AW-1:0]] : 32'h0000_0000;
				tx_path_pkg::REG_SPACE: o_s_axi_rdata <= {12'h000,
					4'(sts_cnt), 11'h000, 5'(FIFO_DEPTH - fifo_cnt)};
				tx_path_pkg::REG_FLAGS: o_s_axi_rdata <= {29'h0, flags};
				tx_path_pkg::REG_THRESH: o_s_axi_rdata <= {24'h0, thresh};
				default: begin
					o_s_axi_rdata <= 32'h0000_0000;
					o_s_axi_rresp <= tx_path_pkg::RESP_SLVERR;
				end
			endcase
		end else if (i_s_axi_rready) begin
			o_s_axi_rvalid <= 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst)
			thresh <= 8'h00;
		else if (do_write && wr_addr == tx_path_pkg::REG_THRESH && wr_strb[0])
			thresh <= wr_data[7:0];
	end

	// 16-bit halves, low half first, into one word
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			half_pending <= 1'b0;
			half_low <= 16'h0000;
		end else if (do_write && wr_addr == tx_path_pkg::REG_DATA) begin
			half_pending <= ~half_pending;
			if (!half_pending)
				half_low <= wr_data[15:0];
		end
	end
	assign data_push = do_write & (wr_addr == tx_path_pkg::REG_DATA) &
		half_pending;
	assign overflow = data_push & (fifo_cnt == 5'(FIFO_DEPTH));

	always_ff @(posedge i_clk_sys) begin
		if (data_push && !overflow)
			fifo_mem[fifo_wp[FIFO_AW-1:0]] <= {wr_data[15:0], half_low};
	end
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			fifo_wp <= '0;
			fifo_rp <= '0;
		end else begin
			if (data_push && !overflow)
				fifo_wp <= fifo_wp + 1'b1;
			if (fifo_pop)
				fifo_rp <= fifo_rp + 1'b1;
		end
	end
	assign fifo_cnt = fifo_wp - fifo_rp;
	assign fifo_empty = (fifo_cnt == '0);

	// buffer geometry from first command
	assign offset = cmd_a[tx_path_pkg::A_OFF_HI:tx_path_pkg::A_OFF_LO];
	assign tot_bytes = {7'h00, offset} + {1'b0, cmd_a[tx_path_pkg::A_SIZE_HI:0]};
	assign wtot = 11'((tot_bytes + 12'h003) >> 2);
	always_comb begin
		case (cmd_a[tx_path_pkg::A_ALIGN_HI:tx_path_pkg::A_ALIGN_LO])
			tx_path_pkg::ALIGN_16: wpad = (wtot + tx_path_pkg::ROUND_16) &
				~tx_path_pkg::ROUND_16;
			tx_path_pkg::ALIGN_32: wpad = (wtot + tx_path_pkg::ROUND_32) &
				~tx_path_pkg::ROUND_32;
			default: wpad = wtot;
		endcase
	end

	// bytes of the current word inside offset..end
	always_comb begin
		keep = 4'h0;
		keep_cnt = 3'h0;
		for (int k = 0; k < 4; k++) begin
			if ({wcnt, 2'(k)} >= {8'h00, offset} &&
				{1'b0, wcnt, 2'(k)} < {1'b0, tot_bytes}) begin
				keep[k] = 1'b1;
				keep_cnt = keep_cnt + 3'h1;
			end
		end
	end

	assign next_pkt_bytes = pkt_bytes + {9'h000, keep_cnt};
	assign len_mismatch = next_pkt_bytes != {1'b0,
		cmd_b_ref[tx_path_pkg::B_LEN_HI:0]};
	assign cmdb_mismatch = (state == tx_path_pkg::ST_CMD_B) & ~fifo_empty &
		~cmd_a[tx_path_pkg::A_FIRST] & (fifo_mem[fifo_rp[FIFO_AW-1:0]] !=
		cmd_b_ref);

	assign obuf_ready = (obuf_cnt != 2'h2);
	// a word wholly before the start offset is dropped, not sent
	assign beat_push = (state == tx_path_pkg::ST_PAYLOAD) & ~fifo_empty &
		obuf_ready & (keep != 4'h0);
	assign fifo_pop = ~fifo_empty & ((state != tx_path_pkg::ST_PAYLOAD) |
		obuf_ready);

	always_comb begin
		beat.data = fifo_mem[fifo_rp[FIFO_AW-1:0]];
		beat.keep = keep;
		beat.buf_end = (wcnt == wtot - 11'h001);
		beat.ioc = cmd_a[tx_path_pkg::A_IOC];
		beat.pkt_end = beat.buf_end & cmd_a[tx_path_pkg::A_LAST];
		beat.err = pkt_err | len_mismatch;
		beat.tag = cmd_b_ref[tx_path_pkg::B_TAG_HI:tx_path_pkg::B_TAG_LO];
		beat.len = next_pkt_bytes[10:0];
	end

	// command, payload and pad sequencing
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			state <= tx_path_pkg::ST_CMD_A;
			cmd_a <= 32'h0000_0000;
			cmd_b_ref <= 32'h0000_0000;
			wcnt <= 11'h000;
			pkt_bytes <= 12'h000;
			pkt_err <= 1'b0;
		end else if (fifo_pop) begin
			case (state)
				tx_path_pkg::ST_CMD_A: begin
					cmd_a <= fifo_mem[fifo_rp[FIFO_AW-1:0]];
					state <= tx_path_pkg::ST_CMD_B;
				end
				tx_path_pkg::ST_CMD_B: begin
					wcnt <= 11'h000;
					if (cmd_a[tx_path_pkg::A_FIRST]) begin
						cmd_b_ref <= fifo_mem[fifo_rp[FIFO_AW-1:0]];
						pkt_bytes <= 12'h000;
						pkt_err <= 1'b0;
					end else if (cmdb_mismatch) begin
						pkt_err <= 1'b1;
					end
					state <= (wtot != 11'h000) ? tx_path_pkg::ST_PAYLOAD :
						tx_path_pkg::ST_CMD_A;
				end
				tx_path_pkg::ST_PAYLOAD: begin
					wcnt <= wcnt + 11'h001;
					pkt_bytes <= next_pkt_bytes;
					if (beat.buf_end)
						state <= (wpad != wtot) ? tx_path_pkg::ST_PAD :
							tx_path_pkg::ST_CMD_A;
				end
				tx_path_pkg::ST_PAD: begin
					wcnt <= wcnt + 11'h001;
					if (wcnt == wpad - 11'h001)
						state <= tx_path_pkg::ST_CMD_A;
				end
				default: state <= tx_path_pkg::ST_CMD_A;
			endcase
		end
	end

	// two-entry output buffer absorbs receiver stalls
	assign out_hs = o_tx_valid & i_tx_ready;
	always_ff @(posedge i_clk_sys) begin
		if (beat_push)
			obuf[obuf_wp] <= beat;
	end
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			obuf_wp <= 1'b0;
			obuf_rp <= 1'b0;
			obuf_cnt <= 2'h0;
		end else begin
			if (beat_push)
				obuf_wp <= ~obuf_wp;
			if (out_hs)
				obuf_rp <= ~obuf_rp;
			obuf_cnt <= obuf_cnt + {1'b0, beat_push} - {1'b0, out_hs};
		end
	end
	assign o_tx_valid = (obuf_cnt != 2'h0);
	assign o_tx_data = obuf[obuf_rp].data;
	assign o_tx_keep = obuf[obuf_rp].keep;
	assign o_tx_last = obuf[obuf_rp].pkt_end;

	// status word per finished packet: tag, error, byte count
	assign sts_full = (sts_cnt == 4'(STS_DEPTH));
	assign sts_push = out_hs & obuf[obuf_rp].pkt_end & ~sts_full;
	always_ff @(posedge i_clk_sys) begin
		if (sts_push)
			sts_mem[sts_wp[STS_AW-1:0]] <= {obuf[obuf_rp].tag,
				obuf[obuf_rp].err, 4'h0, obuf[obuf_rp].len};
	end
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			sts_wp <= '0;
			sts_rp <= '0;
		end else begin
			if (sts_push)
				sts_wp <= sts_wp + 1'b1;
			if (sts_pop)
				sts_rp <= sts_rp + 1'b1;
		end
	end
	assign sts_cnt = sts_wp - sts_rp;
	assign o_status_level_reached = (thresh != 8'h00) &
		({4'h0, sts_cnt} >= thresh);

	// sticky flags, write one to clear, set wins over clear
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			flags <= 3'h0;
		end else begin
			if (do_write && wr_addr == tx_path_pkg::REG_FLAGS && wr_strb[0])
				flags <= flags & ~wr_data[2:0];
			if (overflow || cmdb_mismatch || (beat_push && beat.pkt_end &&
				len_mismatch) || (out_hs && obuf[obuf_rp].pkt_end && sts_full))
				flags[tx_path_pkg::FLAG_TXERR] <= 1'b1;
			if (out_hs && obuf[obuf_rp].buf_end && obuf[obuf_rp].ioc)
				flags[tx_path_pkg::FLAG_DONE] <= 1'b1;
			if (o_status_level_reached)
				flags[tx_path_pkg::FLAG_THRESH] <= 1'b1;
		end
	end
	assign o_tx_error_flag = flags[tx_path_pkg::FLAG_TXERR];
	assign o_buffer_done_flag = flags[tx_path_pkg::FLAG_DONE];

endmodule // tx_buffer_command_path

`default_nettype wire

// ### tx_path_chk.sv
// concurrent checks on the transmit buffer command path ports
`timescale 1ns/1ps
`default_nettype none
module tx_path_chk (
	input wire logic i_clk_sys, // clock
	input wire logic i_rst, // reset
	input wire logic i_s_axi_awvalid, // aw valid
	input wire logic o_s_axi_awready, // aw ready
	input wire logic [31:0] i_s_axi_wdata, // w data
	input wire logic i_s_axi_wvalid, // w valid
	input wire logic o_s_axi_wready, // w ready
	input wire logic o_s_axi_bvalid, // b valid
	input wire logic i_s_axi_bready, // b ready
	input wire logic i_s_axi_arvalid, // ar valid
	input wire logic o_s_axi_arready, // ar ready
	input wire logic [31:0] o_s_axi_rdata, // r data
	input wire logic o_s_axi_rvalid, // r valid
	input wire logic i_s_axi_rready, // r ready
	input wire logic [31:0] o_tx_data, // tx word
	input wire logic [3:0] o_tx_keep, // tx keep
	input wire logic o_tx_last, // tx last
	input wire logic o_tx_valid, // tx valid
	input wire logic i_tx_ready, // tx ready
	input wire logic o_tx_error_flag, // error flag
	input wire logic o_buffer_done_flag // done flag
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	bresp_hold_a: assert property (o_s_axi_bvalid && !i_s_axi_bready
		|=> o_s_axi_bvalid) else $error("write response dropped");
	rdata_hold_a: assert property (o_s_axi_rvalid && !i_s_axi_rready
		|=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
		else $error("read data not held");
	read_answer_a: assert property (i_s_axi_arvalid && o_s_axi_arready
		|=> o_s_axi_rvalid) else $error("read answer late");
	write_answer_a: assert property (i_s_axi_awvalid && o_s_axi_awready
		&& i_s_axi_wvalid && o_s_axi_wready |=> o_s_axi_bvalid)
		else $error("write answer late");
	read_block_a: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
		else $error("read taken while answer pending");
	tx_hold_a: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid
		&& $stable({o_tx_data, o_tx_keep, o_tx_last}))
		else $error("tx word changed under stall");
	pad_dropped_a: assert property (o_tx_valid |-> o_tx_keep != 4'h0)
		else $error("empty tx word sent");
	err_sticky_a: assert property ($fell(o_tx_error_flag) |->
		$past(i_s_axi_wvalid && i_s_axi_wdata[0], 1)
		|| $past(i_s_axi_wvalid && i_s_axi_wdata[0], 2))
		else $error("error flag cleared without write");
	done_sticky_a: assert property ($fell(o_buffer_done_flag) |->
		$past(i_s_axi_wvalid && i_s_axi_wdata[1], 1)
		|| $past(i_s_axi_wvalid && i_s_axi_wdata[1], 2))
		else $error("done flag cleared without write");
	done_cause_a: assert property ($rose(o_buffer_done_flag) |->
		$past(o_tx_valid && i_tx_ready)) else $error("done without send");
endmodule // tx_path_chk
bind tx_buffer_command_path tx_path_chk u_chk (.*);
`default_nettype wire

// ### tx_sink_model.sv
// transmitter stand-in that records words and can stall
`timescale 1ns/1ps
`default_nettype none
module tx_sink_model (
	input wire logic i_clk_sys, // clock
	input wire logic i_rst, // reset
	input wire logic [31:0] i_data, // word
	input wire logic [3:0] i_keep, // keep
	input wire logic i_last, // last
	input wire logic i_valid, // valid
	input wire logic i_stall, // hold ready low
	input wire logic i_slow, // ready every other cycle
	output logic o_ready // accepts word
);
	logic [36:0] q[$];
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst)
			o_ready <= 1'h0;
		else
			o_ready <= !i_stall && !(i_slow && o_ready);
	end
	always @(posedge i_clk_sys) begin
		if (!i_rst && i_valid && o_ready)
			q.push_back({i_last, i_keep, i_data});
	end
endmodule // tx_sink_model
`default_nettype wire

// ### tb_tx_buffer_command_path.sv
// testbench for the transmit buffer command path
`timescale 1ns/1ps
`default_nettype none
module tb_tx_buffer_command_path;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0, stall = 1'h0, slow = 1'h0;
	logic [31:0] wdata = 32'h0, rdata, tx_data, rv;
	logic [3:0] wstrb = 4'h0, tx_keep;
	logic [1:0] bresp, rresp, rsp;
	logic awready, wready, bvalid, arready, rvalid;
	logic tx_last, tx_valid, tx_ready, txerr, done, lvl;
	int err_count = 0;
	int n_checks = 0;
	tx_buffer_command_path DUT (.i_clk_sys(clk), .i_rst(rst),
		.i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
		.o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
		.i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
		.o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
		.o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
		.i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
		.o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
		.o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
		.i_s_axi_rready(rready), .o_tx_data(tx_data), .o_tx_keep(tx_keep),
		.o_tx_last(tx_last), .o_tx_valid(tx_valid), .i_tx_ready(tx_ready),
		.o_tx_error_flag(txerr), .o_buffer_done_flag(done),
		.o_status_level_reached(lvl));
	tx_sink_model sink (.i_clk_sys(clk), .i_rst(rst), .i_data(tx_data),
		.i_keep(tx_keep), .i_last(tx_last), .i_valid(tx_valid),
		.i_stall(stall), .i_slow(slow), .o_ready(tx_ready));
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [36:0] e, g);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// handshakes are judged on settled values before the edge that takes them
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_go, w_go, b_go;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(negedge clk);
			aw_go = ((awvalid & awready) === 1'h1);
			w_go = ((wvalid & wready) === 1'h1);
			b_go = (bvalid === 1'h1);
			if (b_go)
				rsp = bresp;
			@(posedge clk);
			if (aw_go)
				awvalid <= 1'h0;
			if (w_go)
				wvalid <= 1'h0;
		end while (!b_go);
		bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a);
		logic ar_go, r_go;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(negedge clk);
			ar_go = ((arvalid & arready) === 1'h1);
			r_go = (rvalid === 1'h1);
			if (r_go) begin
				rv = rdata;
				rsp = rresp;
			end
			@(posedge clk);
			if (ar_go)
				arvalid <= 1'h0;
		end while (!r_go);
		rready <= 1'h0;
	endtask
	task automatic rc(input logic [7:0] a, input string nm, input logic [31:0] e);
		rd(a);
		chk(nm, e, rv);
	endtask
	// one data word as two half writes, low half first
	task automatic wd(input logic [31:0] w);
		wr(tx_path_pkg::REG_DATA, {16'h0000, w[15:0]});
		wr(tx_path_pkg::REG_DATA, {16'h0000, w[31:16]});
	endtask
	task automatic ex(input logic [31:0] d, input logic [3:0] k, input logic l);
		int n;
		n = 0;
		while (sink.q.size() == 0 && n < 400) begin
			@(posedge clk);
			n++;
		end
		chk("tx word", {l, k, d}, sink.q.size() ? sink.q.pop_front() : 'x);
	endtask
	initial begin
		#500000;
		err_count++;
		give_verdict();
	end
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'h0;
		rc(tx_path_pkg::REG_SPACE, "space", 32'h10);
		rc(tx_path_pkg::REG_FLAGS, "flags", 32'h0);
		rd(8'h20);
		chk("unmapped", {tx_path_pkg::RESP_SLVERR, 32'h0}, {rsp, rv});
		wr(tx_path_pkg::REG_THRESH, 32'h1);
		rc(tx_path_pkg::REG_THRESH, "thresh", 32'h1);
		wd(32'h8101_3006);
		wd(32'h1234_0006);
		wd(32'hA0A1_A2A3);
		wd(32'hB0B1_B2B3);
		repeat (2) wd(32'hEEEE_0000);
		ex(32'hA0A1_A2A3, 4'hE, 1'h0);
		ex(32'hB0B1_B2B3, 4'h7, 1'h1);
		rc(tx_path_pkg::REG_FLAGS, "flags", 32'h6);
		chk("level", 1'h1, lvl);
		rc(tx_path_pkg::REG_STATUS, "status", 32'h1234_0006);
		wr(tx_path_pkg::REG_FLAGS, 32'h7);
		rc(tx_path_pkg::REG_FLAGS, "flags", 32'h0);
		chk("level", 1'h0, lvl);
		rc(tx_path_pkg::REG_STATUS, "status", 32'h0);
		wr(tx_path_pkg::REG_THRESH, 32'h0);
		slow <= 1'h1;
		wd(32'h0200_2004);
		wd(32'h5555_0008);
		wd(32'h1122_3344);
		repeat (7) wd(32'hEEEE_0002);
		wd(32'h0003_1004);
		wd(32'h6666_0008);
		wd(32'hC0C1_C2C3);
		wd(32'hD0D1_D2D3);
		ex(32'h1122_3344, 4'hF, 1'h0);
		ex(32'hC0C1_C2C3, 4'h8, 1'h0);
		ex(32'hD0D1_D2D3, 4'h7, 1'h1);
		rd(tx_path_pkg::REG_STATUS);
		chk("status low", 16'h8008, rv[15:0]);
		rc(tx_path_pkg::REG_FLAGS, "flags", 32'h1);
		wr(tx_path_pkg::REG_FLAGS, 32'h1);
		chk("error port", 1'h0, txerr);
		wd(32'h0000_3004);
		wd(32'h0C0C_0005);
		wd(32'h0102_0304);
		ex(32'h0102_0304, 4'hF, 1'h1);
		rc(tx_path_pkg::REG_STATUS, "status", 32'h0C0C_8004);
		chk("error port", 1'h1, txerr);
		wr(tx_path_pkg::REG_FLAGS, 32'h1);
		rd(tx_path_pkg::REG_DATA);
		chk("data read", tx_path_pkg::RESP_SLVERR, rsp);
		slow <= 1'h0;
		stall <= 1'h1;
		wd(32'h0000_3040);
		wd(32'h0000_0040);
		repeat (20) wd(32'h5A5A_5A5A);
		chk("overflow", 1'h1, txerr);
		rd(tx_path_pkg::REG_SPACE);
		chk("space full", 5'h00, rv[4:0]);
		give_verdict();
	end
endmodule // tb_tx_buffer_command_path
`default_nettype wire
